// [rtl/reset_nmi_powerdown_control.sv]
// Module: reset recognition, reset indication, NMI and power-down interlock.
// Summary of operation
// - Reset input held low with the clock running puts the device in reset.
// - Low pulses shorter than 10 ns on the reset input are ignored.
// - Low pulses longer than 100 ns on the reset input reach reset logic.
// - With bidirectional mode set, device drives reset line low during reset sequence.
// - Reset indication output is low during hardware, software or watchdog reset.
// - Reset indication stays low until end-of-init executes, then goes high.
// - A falling edge on the NMI input outside the reset sequence vectors the CPU to the NMI trap.
// - Power-down instruction enters power-down only when NMI input is low.
// - With NMI high, power-down instruction is ignored and running continues.
// - External access select low around reset: fetch starts from external memory.
// - External access select high around reset: execution starts internally.
// - Bidirectional enable bit locks after end-of-init and clears on any reset.
// - Bidirectional mode stretches short hardware reset; flags report long hardware reset.
`timescale 1ns/100ps
`default_nettype none
module reset_nmi_powerdown_control
  import rst_ctrl_pkg::*;
#(
  parameter int SEQ_CYC = RESET_SEQ_CYC
) (
  input  wire logic      clk_sys,
  input  wire logic      reset,
  input  wire logic      reset_input_pin_in,
  output var  logic      reset_input_pin_out,
  output var  logic      reset_input_pin_oe_n,
  input  wire logic      nmi_n_pin,
  input  wire logic      external_access_select,
  input  wire cpu_req_t  cpu_req,
  output var  logic      reset_indication_output_n,
  output var  cpu_stat_t cpu_stat
);

  // Fewer than two counts leave no room to release the line inside the sequence.
  if (SEQ_CYC < 2) begin : g_bad_seq
    $error("SEQ_CYC must be at least two");
  end

  localparam int SW = $clog2(SEQ_CYC + 1);

  typedef enum logic [1:0] {
    ST_SEQ,
    ST_INIT,
    ST_RUN,
    ST_PDOWN
  } ctrl_state_t;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  // Power-down lies past end-of-init as well, so both count as released.
  function automatic logic past_init(input ctrl_state_t s);
    return (s == ST_RUN) || (s == ST_PDOWN);
  endfunction : past_init

  // True on the last count of the internal sequence.
  function automatic logic seq_last(input logic [SW-1:0] cnt);
    return cnt == SW'(SEQ_CYC - 1);
  endfunction : seq_last

  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  logic rst_level;
  logic nmi_level;
  logic ea_level;

  pin_sync_filter #(.FILTER_CYC(FILTER_PASS_CYC)) u_rst_filt (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (reset_input_pin_in),
    .level_out (rst_level)
  );

  pin_sync_filter #(.FILTER_CYC(1)) u_nmi_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (nmi_n_pin),
    .level_out (nmi_level)
  );

  pin_sync_filter #(.FILTER_CYC(1)) u_ea_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (external_access_select),
    .level_out (ea_level)
  );

  // ----------------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------------
  ctrl_state_t  state_reg;
  logic [SW-1:0] seq_cnt_reg;
  logic          bidir_reg;
  logic          nmi_prev_reg;
  logic          driving_reg;
  reset_cause_t  cause_reg;
  logic          long_hw_reg;
  logic          hw_req;
  logic          any_req;
  logic          enter_seq;

  // While this block drives the line itself, its own low must not retrigger.
  assign hw_req    = !rst_level && !driving_reg;
  assign any_req   = hw_req || cpu_req.software_reset || cpu_req.watchdog_reset;
  // Requests that arrive during the sequence merge into the running one.
  assign enter_seq = any_req && (state_reg != ST_SEQ);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg   <= ST_SEQ;
      seq_cnt_reg <= '0;
      cause_reg   <= RESET_HW;
    end else if (enter_seq) begin
      state_reg   <= ST_SEQ;
      seq_cnt_reg <= '0;
      // A sequence that pulls the line is reported as a hardware reset.
      cause_reg   <= (hw_req || bidir_reg) ? RESET_HW :
                     (cpu_req.watchdog_reset ? RESET_WDT : RESET_SW);
    end else begin
      unique case (state_reg)
        ST_SEQ: begin
          if (seq_last(seq_cnt_reg)) begin
            // The own pull is released on the last count. The line must be
            // seen high through the synchroniser before the sequence ends,
            // or the lagging low would look like a fresh board reset.
            if (!driving_reg && rst_level) begin
              state_reg <= ST_INIT;
            end
          end else if (!rst_level && !driving_reg) begin
            // A board low restarts the count, so reset lasts while it is held.
            seq_cnt_reg <= '0;
          end else begin
            seq_cnt_reg <= seq_cnt_reg + SW'(1);
          end
        end
        ST_INIT: begin
          if (cpu_req.end_of_init_instruction) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (cpu_req.power_down_instruction && !nmi_level) begin
            state_reg <= ST_PDOWN;
          end
        end
        ST_PDOWN: begin
          state_reg <= ST_PDOWN;
        end
      endcase
    end
  end

  // Enable bit: writable only before end-of-init, cleared by every reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bidir_reg <= BIDIR_EN_RST;
    end else if (enter_seq) begin
      bidir_reg <= BIDIR_EN_RST;
    end else if (cpu_req.bidir_reset_enable_wr && state_reg == ST_INIT) begin
      bidir_reg <= cpu_req.bidir_reset_enable_val;
    end
  end

  // The bit is cleared on entry, so the state at the moment of the request
  // decides whether the line is pulled for that sequence.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      driving_reg <= 1'b0;
    end else if (enter_seq) begin
      driving_reg <= bidir_reg;
    end else if (state_reg != ST_SEQ || seq_last(seq_cnt_reg)) begin
      driving_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  // Sticky report of a sequence that pulled the line, kept until the next
  // reset; the pull itself ends early, so it cannot serve as the flag.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      long_hw_reg <= 1'b0;
    end else if (enter_seq) begin
      long_hw_reg <= bidir_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reset_input_pin_out       <= 1'b0;
      reset_input_pin_oe_n      <= 1'b1;
      reset_indication_output_n <= RST_IND_RST;
      nmi_prev_reg              <= 1'b1;
      cpu_stat                  <= '0;
    end else begin
      reset_input_pin_out       <= 1'b0;
      reset_input_pin_oe_n      <= !(driving_reg && state_reg == ST_SEQ);
      reset_indication_output_n <= past_init(state_reg);
      nmi_prev_reg              <= nmi_level;
      cpu_stat.in_reset         <= (state_reg == ST_SEQ);
      cpu_stat.nmi_trap         <= nmi_prev_reg && !nmi_level
                                   && state_reg != ST_SEQ;
      cpu_stat.power_down       <= (state_reg == ST_PDOWN);
      cpu_stat.init_done        <= past_init(state_reg);
      cpu_stat.bidir_reset_enable_bit <= bidir_reg;
      cpu_stat.cause            <= cause_reg;
      cpu_stat.long_hw_reset_flag <= long_hw_reg;
      // The boot source is frozen once the sequence ends, so a late change
      // of the select pin cannot move a running program.
      if (state_reg == ST_SEQ) begin
        cpu_stat.fetch_external <= !ea_level;
      end
    end
  end

endmodule : reset_nmi_powerdown_control
`default_nettype wire

// [rtl/rst_ctrl_pkg.sv]
// Package: constants and carrier types for the reset, NMI and power-down control block.
package rst_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 100;
  localparam int FILTER_PASS_NS       = 100;
  // Longest pass time rounds down, never below one cycle.
  localparam int FILTER_PASS_CYC_RAW  = FILTER_PASS_NS / CLK_PERIOD_NS;
  localparam int FILTER_PASS_CYC      = (FILTER_PASS_CYC_RAW < 1) ? 1 : FILTER_PASS_CYC_RAW;
  localparam int RESET_SEQ_CYC        = 16;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic BIDIR_EN_RST       = 1'b0;
  localparam logic RST_IND_RST        = 1'b0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RESET_NONE,
    RESET_HW,
    RESET_SW,
    RESET_WDT
  } reset_cause_t;

  typedef struct packed {
    logic end_of_init_instruction;
    logic power_down_instruction;
    logic software_reset;
    logic watchdog_reset;
    logic bidir_reset_enable_wr;
    logic bidir_reset_enable_val;
  } cpu_req_t;

  typedef struct packed {
    logic         in_reset;
    logic         nmi_trap;
    logic         power_down;
    logic         fetch_external;
    logic         bidir_reset_enable_bit;
    logic         long_hw_reset_flag;
    logic         init_done;
    reset_cause_t cause;
  } cpu_stat_t;

endpackage : rst_ctrl_pkg

// [rtl/pin_sync_filter.sv]
// Module: two-stage synchroniser with an optional low-pulse filter.
`timescale 1ns/100ps
`default_nettype none
module pin_sync_filter
  import rst_ctrl_pkg::*;
#(
  parameter int FILTER_CYC = 1
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pin_in,
  output var  logic level_out
);

  if (FILTER_CYC < 1) begin : g_bad_filter
    $error("FILTER_CYC must be at least one");
  end

  localparam int CW = $clog2(FILTER_CYC + 1);

  logic          meta_reg;
  logic          sync_reg;
  logic [CW-1:0] low_cnt_reg;

  // Pins idle high, so the synchroniser resets to the inactive level.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  // A low must persist FILTER_CYC samples before it is reported; one sample
  // at 100 ns period can never be a spike shorter than 10 ns wide by itself.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      low_cnt_reg <= '0;
      level_out   <= 1'b1;
    end else if (sync_reg) begin
      low_cnt_reg <= '0;
      level_out   <= 1'b1;
    end else if (low_cnt_reg == CW'(FILTER_CYC - 1)) begin
      level_out   <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_reg + CW'(1);
    end
  end

endmodule : pin_sync_filter
`default_nettype wire

// [test/rst_ctrl_sva.sv]
// Checker: port-level assertions for the reset, NMI and power-down control block.
`timescale 1ns/100ps
`default_nettype none
module rst_ctrl_sva
  import rst_ctrl_pkg::*;
#(
  parameter int SEQ_CYC = 16
) (
  input wire logic      clk_sys,
  input wire logic      reset,
  input wire logic      reset_input_pin_in,
  input wire logic      reset_input_pin_out,
  input wire logic      reset_input_pin_oe_n,
  input wire logic      nmi_n_pin,
  input wire logic      external_access_select,
  input wire cpu_req_t  cpu_req,
  input wire logic      reset_indication_output_n,
  input wire cpu_stat_t cpu_stat
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Only the board may start a hardware reset, never the device's own pull.
  a_pin_starts_reset: assert property ((!reset_input_pin_in && reset_input_pin_oe_n)[*3]
    |-> ##[0:4] cpu_stat.in_reset) else $error("pin reset not taken");
  a_drive_only_low: assert property (!reset_input_pin_out) else $error("pin drives high");
  a_no_drive_run: assert property (reset_indication_output_n |-> reset_input_pin_oe_n)
    else $error("pin driven while running");
  a_soft_reset: assert property ((cpu_req.software_reset || cpu_req.watchdog_reset)
    |-> ##2 (cpu_stat.in_reset && !reset_indication_output_n)) else $error("soft reset missed");
  a_ind_low_seq: assert property (cpu_stat.in_reset |-> !reset_indication_output_n)
    else $error("indication high in reset");
  a_ind_release: assert property ($rose(reset_indication_output_n)
    |-> $past(cpu_req.end_of_init_instruction, 2)) else $error("indication rose alone");
  a_nmi_cause: assert property ($rose(cpu_stat.nmi_trap)
    |-> !$past(nmi_n_pin, 2) && !$past(nmi_n_pin, 3)) else $error("trap without nmi low");
  a_pd_enter: assert property ((!nmi_n_pin)[*4] ##0 (cpu_req.power_down_instruction
    && reset_indication_output_n) |-> ##2 cpu_stat.power_down) else $error("no power down");
  a_pd_refuse: assert property (nmi_n_pin[*4] ##0 (cpu_req.power_down_instruction
    && !cpu_stat.power_down) |-> ##2 !cpu_stat.power_down) else $error("power down with nmi high");
  a_boot_source: assert property ($fell(cpu_stat.in_reset)
    |-> cpu_stat.fetch_external == !$past(external_access_select, 2)) else $error("boot source");
  a_bidir_locked: assert property (reset_indication_output_n && $past(reset_indication_output_n)
    |-> $stable(cpu_stat.bidir_reset_enable_bit)) else $error("bidir bit changed after init");
endmodule : rst_ctrl_sva
bind reset_nmi_powerdown_control rst_ctrl_sva #(.SEQ_CYC(SEQ_CYC)) u_sva (
  .clk_sys(clk_sys), .reset(reset), .reset_input_pin_in(reset_input_pin_in),
  .reset_input_pin_out(reset_input_pin_out), .reset_input_pin_oe_n(reset_input_pin_oe_n),
  .nmi_n_pin(nmi_n_pin), .external_access_select(external_access_select), .cpu_req(cpu_req),
  .reset_indication_output_n(reset_indication_output_n), .cpu_stat(cpu_stat));
`default_nettype wire

// [test/board_model.sv]
// Board model: open-drain reset line with pull-up, reset source and NMI source.
`timescale 1ns/100ps
`default_nettype none
module board_model (
  input  wire logic clk_sys,
  input  wire logic pin_out,
  input  wire logic oe_n,
  output var  logic rst_line,
  output var  logic nmi_line
);
  logic pull_low = 1'b0;
  logic nmi_low  = 1'b0;
  // Wired-and with a pull-up: either side may pull the line, neither drives it high.
  always_comb rst_line = !(pull_low || (!oe_n && !pin_out));
  // An idle NMI input is pulled high on the board.
  always_comb nmi_line = !nmi_low;
  // Hold time covers 100 ns plus two clocks; the long settling time is cut short in sim.
  task automatic hold_reset(input int n);
    @(posedge clk_sys) pull_low <= 1'b1;
    repeat (n) @(posedge clk_sys);
    pull_low <= 1'b0;
  endtask : hold_reset
  task automatic spike();
    @(posedge clk_sys) #40 pull_low = 1'b1;
    #5 pull_low = 1'b0;
  endtask : spike
  task automatic set_nmi(input logic v);
    @(posedge clk_sys) nmi_low <= !v;
  endtask : set_nmi
endmodule : board_model
`default_nettype wire

// [test/reset_nmi_powerdown_control_tb.sv]
// Testbench: reset sources, indication, bidirectional mode, NMI and power-down.
`timescale 1ns/100ps
`default_nettype none
module reset_nmi_powerdown_control_tb
  import rst_ctrl_pkg::*;
;
  logic      clk_sys = 1'b0, reset = 1'b1, ea = 1'b1;
  logic      rst_line, nmi_line, pin_out, oe_n, ind_n, seen;
  cpu_req_t  req = '0;
  cpu_stat_t st;
  int        n_errors = 0, tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  reset_nmi_powerdown_control #(.SEQ_CYC(4)) dut (.clk_sys(clk_sys), .reset(reset),
    .reset_input_pin_in(rst_line), .reset_input_pin_out(pin_out), .reset_input_pin_oe_n(oe_n),
    .nmi_n_pin(nmi_line), .external_access_select(ea), .cpu_req(req),
    .reset_indication_output_n(ind_n), .cpu_stat(st));
  board_model board (.clk_sys(clk_sys), .pin_out(pin_out), .oe_n(oe_n), .rst_line(rst_line),
    .nmi_line(nmi_line));
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input cpu_req_t r);
    @(posedge clk_sys) req <= r;
    @(posedge clk_sys) req <= '0;
  endtask : pulse
  task automatic wait_rst(input logic v);
    for (int i = 0; i < 60 && st.in_reset !== v; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(st.in_reset, v);
  endtask : wait_rst
  // Lets the sequence run out, then ends initialisation.
  task automatic boot(input logic x);
    wait_rst(1'b0);
    chk(st.fetch_external, !x);
    chk(ind_n, 1'b0);
    chk(st.init_done, 1'b0);
    pulse(6'h20);
    repeat (2) @(posedge clk_sys);
    #1 chk(ind_n, 1'b1);
    chk(st.init_done, 1'b1);
  endtask : boot
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_power_on();
    wait_rst(1'b1);
    chk(ind_n, 1'b0);
    chk(oe_n, 1'b1);
    boot(1'b1);
    $display("power-on reset done");
  endtask : t_power_on
  task automatic t_soft(input cpu_req_t r, input logic [1:0] c, input logic x);
    @(posedge clk_sys) ea <= x;
    pulse(r);
    wait_rst(1'b1);
    chk(st.cause, c);
    chk(ind_n, 1'b0);
    boot(x);
    $display("soft reset %h done", r);
  endtask : t_soft
  task automatic t_pin();
    board.hold_reset(4);
    wait_rst(1'b1);
    chk(st.cause, RESET_HW);
    boot(1'b1);
    board.spike();
    repeat (8) @(posedge clk_sys);
    #1 chk(st.in_reset, 1'b0);
    $display("pin reset done");
  endtask : t_pin
  task automatic t_bidir();
    pulse(6'h08);
    wait_rst(1'b1);
    wait_rst(1'b0);
    pulse(6'h03);
    @(posedge clk_sys);
    #1 chk(st.bidir_reset_enable_bit, 1'b1);
    boot(1'b1);
    pulse(6'h02);
    repeat (2) @(posedge clk_sys);
    #1 chk(st.bidir_reset_enable_bit, 1'b1);
    pulse(6'h08);
    wait_rst(1'b1);
    chk(rst_line, 1'b0);
    wait_rst(1'b0);
    chk(st.bidir_reset_enable_bit, 1'b0);
    chk(st.long_hw_reset_flag, 1'b1);
    boot(1'b1);
    $display("bidirectional reset done");
  endtask : t_bidir
  task automatic t_nmi();
    pulse(6'h10);
    repeat (3) @(posedge clk_sys);
    #1 chk(st.power_down, 1'b0);
    board.set_nmi(1'b0);
    seen = 1'b0;
    repeat (8) begin
      @(posedge clk_sys);
      #1 if (st.nmi_trap === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1);
    pulse(6'h10);
    repeat (3) @(posedge clk_sys);
    #1 chk(st.power_down, 1'b1);
    pulse(6'h04);
    wait_rst(1'b1);
    chk(st.power_down, 1'b0);
    chk(st.cause, RESET_WDT);
    $display("nmi and power down done");
  endtask : t_nmi
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_power_on();
    t_soft(6'h08, RESET_SW, 1'b0);
    t_soft(6'h04, RESET_WDT, 1'b1);
    t_pin();
    t_bidir();
    t_nmi();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    end_sim();
  end
endmodule : reset_nmi_powerdown_control_tb
`default_nettype wire
